/* File: hw/ppr_regs.svh */
// Function
// - ports A to E each hold an 8-bit read/write output latch, reset zero.
// - ports A to E each hold an 8-bit read/write direction register, reset zero.
// - each port has a read-only pin-level register; writes to it store nothing.
// - short-form I/O accesses decode only address bits 5:0, so higher addresses alias onto 0x00 to 0x3F.
// - data-space accesses see low I/O registers at their offset plus 0x20.
// - extended area from 0x60 is reachable only by data-space loads and stores.
// - port F output latch sits at extended address 0x62, 8 bits, reset zero.
// - in compatibility mode port C pins are driven outputs carrying the port C output latch.
// - port C compatibility state applies from reset without a running clock.
// - global pull-up disable suppresses every pull-up, even when requested.
// - in compatibility mode port F latches are unavailable; port F is input only.
`ifndef PPR_REGS_SVH
`define PPR_REGS_SVH

`define PPR_OFS_F_PIN_LEVELS    6'h00
`define PPR_OFS_E_PIN_LEVELS    6'h01
`define PPR_OFS_E_DIRECTION     6'h02
`define PPR_OFS_E_OUTPUT_LATCH  6'h03
`define PPR_OFS_D_PIN_LEVELS    6'h10
`define PPR_OFS_D_DIRECTION     6'h11
`define PPR_OFS_D_OUTPUT_LATCH  6'h12
`define PPR_OFS_C_PIN_LEVELS    6'h13
`define PPR_OFS_C_DIRECTION     6'h14
`define PPR_OFS_C_OUTPUT_LATCH  6'h15
`define PPR_OFS_B_PIN_LEVELS    6'h16
`define PPR_OFS_B_DIRECTION     6'h17
`define PPR_OFS_B_OUTPUT_LATCH  6'h18
`define PPR_OFS_A_PIN_LEVELS    6'h19
`define PPR_OFS_A_DIRECTION     6'h1A
`define PPR_OFS_A_OUTPUT_LATCH  6'h1B
`define PPR_OFS_SPECIAL_FUNC    6'h20

`define PPR_EXT_F_DIRECTION     8'h61
`define PPR_EXT_F_OUTPUT_LATCH  8'h62

`define PPR_DM_IO_BASE          16'h0020
`define PPR_DM_IO_LAST          16'h005F
`define PPR_DM_EXT_BASE         16'h0060
`define PPR_DM_EXT_LAST         16'h00FF

`define PPR_PULLUP_OFF_BIT      2
`define PPR_LATCH_RESET         8'h00
`define PPR_READ_UNMAPPED       8'h00

`endif

/* File: hw/ppr_pkg.sv */
package ppr_pkg;

	typedef enum logic {
		PPR_SPACE_IO,
		PPR_SPACE_DATA
	} ppr_space_t;

	// one processor access, short-form I/O or data-space load/store
	typedef struct packed {
		logic       valid;
		logic       write;
		ppr_space_t space;
		logic [15:0] addr;
		logic [7:0] wdata;
	} ppr_access_t;

	// decoded target of an access
	typedef struct packed {
		logic       hit;
		logic       ext;
		logic [7:0] idx;
	} ppr_sel_t;

	typedef enum logic [2:0] {
		PPR_PORT_A,
		PPR_PORT_B,
		PPR_PORT_C,
		PPR_PORT_D,
		PPR_PORT_E,
		PPR_PORT_F
	} ppr_port_t;

endpackage : ppr_pkg

/* File: hw/ppr_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module ppr_pin_sync #(
	parameter int W = 8
) (
	input  wire logic         ref_clk,   // system clock
	input  wire logic         rst_n,     // async reset, active low
	input  wire logic [W-1:0] pins_in,   // raw pin levels
	output var  logic [W-1:0] level      // filtered level
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= pins_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (stage2[i] == stage3[i]) begin
					level[i] <= stage3[i];
				end
			end
		end
	end

endmodule : ppr_pin_sync
`default_nettype wire

/* File: hw/ppr_addr_decode.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ppr_regs.svh"
module ppr_addr_decode import ppr_pkg::*; (
	input  wire ppr_access_t req,   // processor access
	output var  ppr_sel_t    sel    // decoded target
);

	always_comb begin
		sel = '0;
		if (req.valid) begin
			if (req.space == PPR_SPACE_IO) begin
				sel.hit = 1'b1;
				sel.idx = {2'b00, req.addr[5:0]};
			end else if (req.addr >= `PPR_DM_IO_BASE && req.addr <= `PPR_DM_IO_LAST) begin
				sel.hit = 1'b1;
				sel.idx = {2'b00, 6'(req.addr - `PPR_DM_IO_BASE)};
			end else if (req.addr >= `PPR_DM_EXT_BASE && req.addr <= `PPR_DM_EXT_LAST) begin
				sel.hit = 1'b1;
				sel.ext = 1'b1;
				sel.idx = req.addr[7:0];
			end
		end
	end

endmodule : ppr_addr_decode
`default_nettype wire

/* File: hw/ppr_port_bank.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ppr_regs.svh"
module ppr_port_bank import ppr_pkg::*; #(
	parameter int W     = 8,
	parameter int PORTS = 6
) (
	input  wire logic                   ref_clk,      // system clock, 125 MHz
	input  wire logic                   rst_n,        // async reset, active low
	input  wire ppr_access_t            req,          // processor register access
	input  wire logic                   compat_mode,  // legacy mode strap
	input  wire logic [PORTS-1:0][W-1:0] port_pins,   // pin levels, A..F
	output var  logic [7:0]             rd_data,      // read answer
	output var  logic                   rd_valid,     // read answer strobe
	output var  logic [PORTS-1:0][W-1:0] pad_out,     // pad output value
	output var  logic [PORTS-1:0][W-1:0] pad_oe_n,    // pad drive enable, low drives
	output var  logic [PORTS-1:0][W-1:0] pad_pullup,  // pad pull-up enable
	output var  logic                   compat_active // captured legacy mode
);

	localparam int LATCHED = 5;

	ppr_sel_t                sel;
	logic [PORTS-1:0][W-1:0] level;
	logic [PORTS-1:0][W-1:0] out_latch;
	logic [PORTS-1:0][W-1:0] dir_reg;
	logic                    pullup_global_off;
	logic                    strap_taken;
	logic [PORTS-1:0]        wr_out;
	logic [PORTS-1:0]        wr_dir;
	logic                    wr_special;
	logic [7:0]              next_rd_data;
	logic                    next_rd_valid;

	function automatic logic [5:0] out_ofs(input int p);
		case (p)
			0:       out_ofs = `PPR_OFS_A_OUTPUT_LATCH;
			1:       out_ofs = `PPR_OFS_B_OUTPUT_LATCH;
			2:       out_ofs = `PPR_OFS_C_OUTPUT_LATCH;
			3:       out_ofs = `PPR_OFS_D_OUTPUT_LATCH;
			default: out_ofs = `PPR_OFS_E_OUTPUT_LATCH;
		endcase
	endfunction : out_ofs

	function automatic logic [5:0] dir_ofs(input int p);
		case (p)
			0:       dir_ofs = `PPR_OFS_A_DIRECTION;
			1:       dir_ofs = `PPR_OFS_B_DIRECTION;
			2:       dir_ofs = `PPR_OFS_C_DIRECTION;
			3:       dir_ofs = `PPR_OFS_D_DIRECTION;
			default: dir_ofs = `PPR_OFS_E_DIRECTION;
		endcase
	endfunction : dir_ofs

	function automatic logic [5:0] pin_ofs(input int p);
		case (p)
			0:       pin_ofs = `PPR_OFS_A_PIN_LEVELS;
			1:       pin_ofs = `PPR_OFS_B_PIN_LEVELS;
			2:       pin_ofs = `PPR_OFS_C_PIN_LEVELS;
			3:       pin_ofs = `PPR_OFS_D_PIN_LEVELS;
			4:       pin_ofs = `PPR_OFS_E_PIN_LEVELS;
			default: pin_ofs = `PPR_OFS_F_PIN_LEVELS;
		endcase
	endfunction : pin_ofs

	ppr_addr_decode u_decode (
		.req (req),
		.sel (sel)
	);

	ppr_pin_sync #(
		.W (PORTS * W)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pins_in (port_pins),
		.level   (level)
	);

	// register selection and read mux
	always_comb begin
		wr_out        = '0;
		wr_dir        = '0;
		wr_special    = 1'b0;
		next_rd_data  = `PPR_READ_UNMAPPED;
		next_rd_valid = req.valid && !req.write;
		if (sel.hit && !sel.ext) begin
			for (int p = 0; p < LATCHED; p++) begin
				if (sel.idx[5:0] == out_ofs(p)) begin
					wr_out[p]    = req.write;
					next_rd_data = out_latch[p];
				end
				if (sel.idx[5:0] == dir_ofs(p)) begin
					wr_dir[p]    = req.write;
					next_rd_data = dir_reg[p];
				end
			end
			for (int p = 0; p < PORTS; p++) begin
				if (sel.idx[5:0] == pin_ofs(p)) begin
					next_rd_data = level[p];
				end
			end
			if (sel.idx[5:0] == `PPR_OFS_SPECIAL_FUNC) begin
				wr_special = req.write;
				next_rd_data = 8'h00;
				next_rd_data[`PPR_PULLUP_OFF_BIT] = pullup_global_off;
			end
		end else if (sel.hit && sel.ext && !compat_active) begin
			// extended area, reached only from the data-space decode
			case (sel.idx)
				`PPR_EXT_F_OUTPUT_LATCH: begin
					wr_out[PPR_PORT_F] = req.write;
					next_rd_data       = out_latch[PPR_PORT_F];
				end
				`PPR_EXT_F_DIRECTION: begin
					wr_dir[PPR_PORT_F] = req.write;
					next_rd_data       = dir_reg[PPR_PORT_F];
				end
				default: begin
					next_rd_data = `PPR_READ_UNMAPPED;
				end
			endcase
		end
	end

	// strap capture; resets to legacy so port C drives zero with no clock
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			compat_active <= 1'b1;
			strap_taken   <= 1'b0;
		end else if (!strap_taken) begin
			compat_active <= compat_mode;
			strap_taken   <= 1'b1;
		end
	end

	// output latches
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_latch <= '0;
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				if (wr_out[p]) begin
					out_latch[p] <= req.wdata;
				end
			end
		end
	end

	// direction registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_reg <= '0;
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				if (wr_dir[p]) begin
					dir_reg[p] <= req.wdata;
				end
			end
		end
	end

	// global pull-up disable
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pullup_global_off <= 1'b0;
		end else if (wr_special) begin
			pullup_global_off <= req.wdata[`PPR_PULLUP_OFF_BIT];
		end
	end

	// read answer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_data  <= next_rd_data;
			rd_valid <= next_rd_valid;
		end
	end

	// pad drive; port C starts as driven zero under reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out    <= '0;
			pad_oe_n   <= '1;
			pad_pullup <= '0;
			pad_oe_n[PPR_PORT_C] <= 8'h00;
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				pad_out[p]    <= out_latch[p] & dir_reg[p];
				pad_oe_n[p]   <= ~dir_reg[p];
				pad_pullup[p] <= pullup_global_off ? 8'h00 : (~dir_reg[p] & out_latch[p]);
			end
			if (compat_active) begin
				pad_out[PPR_PORT_C]    <= out_latch[PPR_PORT_C];
				pad_oe_n[PPR_PORT_C]   <= 8'h00;
				pad_pullup[PPR_PORT_C] <= 8'h00;
				pad_out[PPR_PORT_F]    <= 8'h00;
				pad_oe_n[PPR_PORT_F]   <= 8'hFF;
				pad_pullup[PPR_PORT_F] <= 8'h00;
			end
		end
	end

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic io_wr;
	logic dm_wr;
	assign io_wr = req.valid && req.write && req.space == PPR_SPACE_IO;
	assign dm_wr = req.valid && req.write && req.space == PPR_SPACE_DATA;

	property p_a_latch_write;
		io_wr && req.addr[5:0] == `PPR_OFS_A_OUTPUT_LATCH |=> out_latch[PPR_PORT_A] == $past(req.wdata);
	endproperty
	a_a_latch_write: assert property (p_a_latch_write) else $error("port A latch write lost");

	property p_b_dir_to_pad;
		io_wr && req.addr[5:0] == `PPR_OFS_B_DIRECTION |-> ##2 pad_oe_n[PPR_PORT_B] == ~$past(req.wdata, 2);
	endproperty
	a_b_dir_to_pad: assert property (p_b_dir_to_pad) else $error("port B direction not on pads");

	property p_pin_write_inert;
		io_wr && req.addr[5:0] == `PPR_OFS_B_PIN_LEVELS |=> $stable(out_latch) && $stable(dir_reg);
	endproperty
	a_pin_write_inert: assert property (p_pin_write_inert) else $error("pin level write stored");

	property p_pin_read;
		req.valid && !req.write && req.space == PPR_SPACE_IO && req.addr[5:0] == `PPR_OFS_E_PIN_LEVELS
			|=> rd_valid && rd_data == $past(level[PPR_PORT_E]);
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin level read wrong");

	property p_io_special;
		io_wr && req.addr[5:0] == `PPR_OFS_SPECIAL_FUNC |=> pullup_global_off == $past(req.wdata[`PPR_PULLUP_OFF_BIT]);
	endproperty
	a_io_special: assert property (p_io_special) else $error("io decode missed top register");

	property p_dm_offset;
		dm_wr && req.addr == `PPR_DM_IO_BASE + 16'(`PPR_OFS_C_OUTPUT_LATCH)
			|=> out_latch[PPR_PORT_C] == $past(req.wdata);
	endproperty
	a_dm_offset: assert property (p_dm_offset) else $error("data-space offset not applied");

	property p_io_no_ext;
		io_wr |=> $stable(out_latch[PPR_PORT_F]) && $stable(dir_reg[PPR_PORT_F]);
	endproperty
	a_io_no_ext: assert property (p_io_no_ext) else $error("io access reached extended area");

	property p_f_latch;
		dm_wr && !compat_active && req.addr == 16'({8'h00, `PPR_EXT_F_OUTPUT_LATCH})
			|=> out_latch[PPR_PORT_F] == $past(req.wdata);
	endproperty
	a_f_latch: assert property (p_f_latch) else $error("port F latch write lost");

	property p_c_compat;
		compat_active && $past(compat_active) |-> pad_oe_n[PPR_PORT_C] == 8'h00;
	endproperty
	a_c_compat: assert property (p_c_compat) else $error("port C not driven in legacy mode");

	property p_pullup_off;
		$past(pullup_global_off) |-> pad_pullup == '0;
	endproperty
	a_pullup_off: assert property (p_pullup_off) else $error("pull-up active while disabled");

	property p_f_compat;
		compat_active && $past(compat_active) |-> pad_oe_n[PPR_PORT_F] == 8'hFF && !wr_out[PPR_PORT_F];
	endproperty
	a_f_compat: assert property (p_f_compat) else $error("port F driven in legacy mode");

	property p_e_latch_write;
		io_wr && req.addr[5:0] == `PPR_OFS_E_OUTPUT_LATCH
			|=> out_latch[PPR_PORT_E] == $past(req.wdata);
	endproperty
	a_e_latch_write: assert property (p_e_latch_write) else $error("port E latch write lost");

	property p_dir_write;
		dm_wr && req.addr == `PPR_DM_IO_BASE + 16'(`PPR_OFS_E_DIRECTION)
			|=> dir_reg[PPR_PORT_E] == $past(req.wdata);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("port E direction write lost");

	property p_rd_answer;
		req.valid && !req.write
			|=> rd_valid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

	property p_rd_quiet;
		!(req.valid && !req.write)
			|=> !rd_valid;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read answer without read");

	property p_dm_pin_read;
		req.valid && !req.write && req.space == PPR_SPACE_DATA && req.addr == `PPR_DM_IO_BASE + 16'(`PPR_OFS_B_PIN_LEVELS)
			|=> rd_data == $past(level[PPR_PORT_B]);
	endproperty
	a_dm_pin_read: assert property (p_dm_pin_read) else $error("data-space pin read wrong");

	property p_io_high_unmapped;
		req.valid && !req.write && req.space == PPR_SPACE_IO && req.addr[5:0] > `PPR_OFS_SPECIAL_FUNC
			|=> rd_data == `PPR_READ_UNMAPPED;
	endproperty
	a_io_high_unmapped: assert property (p_io_high_unmapped) else $error("io read hit a register");

	property p_f_blocked;
		dm_wr && compat_active
			|=> $stable(out_latch[PPR_PORT_F]) && $stable(dir_reg[PPR_PORT_F]);
	endproperty
	a_f_blocked: assert property (p_f_blocked) else $error("port F written in legacy mode");

	property p_f_read_blocked;
		req.valid && !req.write && compat_active && req.space == PPR_SPACE_DATA && req.addr == 16'h0062
			|=> rd_data == `PPR_READ_UNMAPPED;
	endproperty
	a_f_read_blocked: assert property (p_f_read_blocked) else $error("port F read in legacy mode");

	property p_pullup_on;
		!$past(pullup_global_off)
			|-> pad_pullup[PPR_PORT_A] == (~$past(dir_reg[PPR_PORT_A]) & $past(out_latch[PPR_PORT_A]));
	endproperty
	a_pullup_on: assert property (p_pullup_on) else $error("port A pull-up wrong");

	property p_a_drive;
		pad_out[PPR_PORT_A] == ($past(out_latch[PPR_PORT_A]) & $past(dir_reg[PPR_PORT_A]))
			&& pad_oe_n[PPR_PORT_A] == ~$past(dir_reg[PPR_PORT_A]);
	endproperty
	a_a_drive: assert property (p_a_drive) else $error("port A pads wrong");

	property p_c_legacy_out;
		compat_active && $past(compat_active)
			|-> pad_out[PPR_PORT_C] == $past(out_latch[PPR_PORT_C]);
	endproperty
	a_c_legacy_out: assert property (p_c_legacy_out) else $error("port C legacy value wrong");

	c_dm_read:   cover property (req.valid && !req.write && req.space == PPR_SPACE_DATA ##1 rd_valid);
	c_pullup:    cover property (pad_pullup != '0 ##1 pullup_global_off);
	c_f_write:   cover property (wr_out[PPR_PORT_F] ##2 pad_out[PPR_PORT_F] != 8'h00);
	c_compat_on: cover property (strap_taken && compat_active);
	c_c_legacy:  cover property (compat_active && wr_out[PPR_PORT_C]);

endmodule : ppr_port_bank
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import ppr_pkg::*;

	logic                ref_clk;
	logic                rst_n;
	ppr_access_t         req;
	logic                compat_mode;
	logic [5:0][7:0]     port_pins;
	logic [7:0]          rd_data;
	logic                rd_valid;
	logic [5:0][7:0]     pad_out;
	logic [5:0][7:0]     pad_oe_n;
	logic [5:0][7:0]     pad_pullup;
	logic                compat_active;
	int                  fails;
	int                  check_count;
	int                  cyc;
	logic [7:0]          base [5];
	logic [7:0]          lv;
	logic [7:0]          dv;

	ppr_port_bank #(.W(8), .PORTS(6)) dut (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.req           (req),
		.compat_mode   (compat_mode),
		.port_pins     (port_pins),
		.rd_data       (rd_data),
		.rd_valid      (rd_valid),
		.pad_out       (pad_out),
		.pad_oe_n      (pad_oe_n),
		.pad_pullup    (pad_pullup),
		.compat_active (compat_active)
	);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic test_done;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	// hang guard, run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails = fails + 1;
			test_done();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one access: set at a falling edge, taken at the next rising edge, answer one edge later
	task automatic acc(input logic w, input ppr_space_t sp, input logic [15:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(negedge ref_clk);
		req = '{valid: 1'b1, write: w, space: sp, addr: a, wdata: d};
		@(negedge ref_clk);
		q = rd_data;
		if (!w) begin
			chk({7'h00, rd_valid}, 8'h01);
		end
		req.valid = 1'b0;
	endtask : acc

	task automatic wr(input ppr_space_t sp, input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, sp, a, d, q);
	endtask : wr

	task automatic rd_chk(input ppr_space_t sp, input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] q;
		acc(1'b0, sp, a, 8'h00, q);
		chk(q, exp);
	endtask : rd_chk

	// pads follow a write one rising edge after the register
	task automatic settle;
		@(negedge ref_clk);
	endtask : settle

	task automatic do_reset(input logic cm);
		@(negedge ref_clk);
		compat_mode = cm;
		rst_n = 1'b0;
		#1;
		chk(pad_oe_n[2], 8'h00);
		chk(pad_out[2], 8'h00);
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
	endtask : do_reset

	initial begin
		rst_n = 1'b0;
		compat_mode = 1'b0;
		req = '0;
		port_pins = '0;
		fails = 0;
		check_count = 0;
		cyc = 0;
		base = '{8'h19, 8'h16, 8'h13, 8'h10, 8'h01};
		do_reset(1'b0);
		chk({7'h00, compat_active}, 8'h00);
		for (int p = 0; p < 5; p++) begin
			rd_chk(PPR_SPACE_IO, {8'h00, base[p] + 8'h01}, 8'h00);
			rd_chk(PPR_SPACE_DATA, {8'h00, base[p] + 8'h22}, 8'h00);
		end
		rd_chk(PPR_SPACE_DATA, 16'h0062, 8'h00);
		chk(pad_oe_n[0], 8'hFF);
		chk(pad_pullup[0], 8'h00);
		$display("test reset_values done");

		for (int p = 0; p < 5; p++) begin
			lv = 8'hA0 | 8'(p);
			dv = 8'h5C ^ 8'(p);
			wr(PPR_SPACE_IO, {8'h00, base[p] + 8'h02}, lv);
			wr(PPR_SPACE_DATA, {8'h00, base[p] + 8'h21}, dv);
			settle();
			chk(pad_out[p], lv & dv);
			chk(pad_oe_n[p], ~dv);
			chk(pad_pullup[p], lv & ~dv);
			rd_chk(PPR_SPACE_DATA, {8'h00, base[p] + 8'h22}, lv);
			rd_chk(PPR_SPACE_IO, {8'h00, base[p] + 8'h01}, dv);
		end
		rd_chk(PPR_SPACE_IO, 16'h005B, 8'hA0);
		$display("test latch_direction done");

		for (int p = 0; p < 6; p++) begin
			port_pins[p] = 8'h3C ^ 8'(p * 17);
		end
		repeat (6) @(negedge ref_clk);
		for (int p = 0; p < 5; p++) begin
			rd_chk(PPR_SPACE_IO, {8'h00, base[p]}, 8'h3C ^ 8'(p * 17));
		end
		rd_chk(PPR_SPACE_IO, 16'h0000, 8'h3C ^ 8'h55);
		wr(PPR_SPACE_IO, {8'h00, base[1]}, 8'hFF);
		rd_chk(PPR_SPACE_DATA, {8'h00, base[1] + 8'h20}, 8'h3C ^ 8'h11);
		$display("test pin_levels done");

		wr(PPR_SPACE_DATA, 16'h0061, 8'hF0);
		wr(PPR_SPACE_DATA, 16'h0062, 8'h3C);
		settle();
		chk(pad_out[5], 8'h30);
		chk(pad_oe_n[5], 8'h0F);
		rd_chk(PPR_SPACE_DATA, 16'h0061, 8'hF0);
		rd_chk(PPR_SPACE_DATA, 16'h0062, 8'h3C);
		wr(PPR_SPACE_IO, 16'h0062, 8'h99);
		rd_chk(PPR_SPACE_DATA, 16'h0062, 8'h3C);
		rd_chk(PPR_SPACE_IO, 16'h0062, 8'h00);
		rd_chk(PPR_SPACE_DATA, 16'h0010, 8'h00);
		rd_chk(PPR_SPACE_DATA, 16'h0100, 8'h00);
		$display("test address_map done");

		wr(PPR_SPACE_IO, 16'h001A, 8'h00);
		wr(PPR_SPACE_IO, 16'h001B, 8'hFF);
		settle();
		chk(pad_pullup[0], 8'hFF);
		wr(PPR_SPACE_IO, 16'h0020, 8'h04);
		settle();
		chk(pad_pullup[0], 8'h00);
		rd_chk(PPR_SPACE_DATA, 16'h0040, 8'h04);
		wr(PPR_SPACE_DATA, 16'h0040, 8'h00);
		settle();
		chk(pad_pullup[0], 8'hFF);
		$display("test pullup_off done");

		do_reset(1'b1);
		chk({7'h00, compat_active}, 8'h01);
		chk(pad_oe_n[2], 8'h00);
		chk(pad_out[2], 8'h00);
		wr(PPR_SPACE_DATA, 16'h0035, 8'h81);
		settle();
		chk(pad_out[2], 8'h81);
		chk(pad_oe_n[2], 8'h00);
		rd_chk(PPR_SPACE_IO, 16'h0014, 8'h00);
		wr(PPR_SPACE_DATA, 16'h0062, 8'h77);
		rd_chk(PPR_SPACE_DATA, 16'h0062, 8'h00);
		wr(PPR_SPACE_DATA, 16'h0061, 8'hFF);
		rd_chk(PPR_SPACE_DATA, 16'h0061, 8'h00);
		chk(pad_oe_n[5], 8'hFF);
		rd_chk(PPR_SPACE_IO, 16'h0000, 8'h3C ^ 8'h55);
		$display("test compat_mode done");
		test_done();
	end
endmodule : tb
`default_nettype wire
